/* File: core/uas_defines.vh */
// Constants for the application-service packet parser.
// Included by the settings store and the command parser; definitions only.
`ifndef UAS_DEFINES_VH
`define UAS_DEFINES_VH
`define UAS_ID_SERIAL      8'h00
`define UAS_ID_CONFIG      8'h02
`define UAS_ID_ACK         8'h80
`define UAS_ID_CONFIG_RSP  8'h82
`define UAS_OPT_NONE       8'h00
`define UAS_OPT_ACK_BIT    1
`define UAS_CFG_QUEUE      8'h00
`define UAS_CFG_APPLY      8'h02
`define UAS_ST_OK          8'h00
`define UAS_ST_ERROR       8'h01
`define UAS_ST_BAD_CMD     8'h02
`define UAS_ST_BAD_PARAM   8'h03
`define UAS_OFF_ID         11'h000
`define UAS_OFF_OPT        11'h001
`define UAS_OFF_FRAME      11'h002
`define UAS_OFF_CFGOPT     11'h003
`define UAS_OFF_NAME_HI    11'h004
`define UAS_OFF_NAME_LO    11'h005
`define UAS_OFF_VALUE      11'h007
`define UAS_SERIAL_START   11'h002
`define UAS_SERIAL_MAX     11'h578
`define UAS_FIFO_WIDTH     8
`define UAS_FIFO_DEPTH     16
`endif

/* File: core/uas_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; width and depth set by parameters, depth a power of two.
`timescale 1ns/1ps
module uas_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

/* File: core/uas_settings.v */
// Small store of configuration settings addressed by two-character names.
// Pending writes are held until an apply pulse; reads return the active value.
// Assumes one clock and single-byte settings.
`timescale 1ns/1ps
`include "uas_defines.vh"
module uas_settings #(
    parameter NUM = 4
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [15:0] name,
    input  wire        wr,
    input  wire [7:0]  wr_value,
    input  wire        apply,
    output reg         known,
    output reg  [7:0]  rd_value,
    output reg         value_ok
);
    reg [7:0] active  [0:NUM-1];
    reg [7:0] pending [0:NUM-1];
    reg [NUM-1:0] dirty;
    reg [NUM-1:0] hit;
    integer i;
    integer j;

    // Setting names: arbitrary example set, index order matters
    function [15:0] slot_name;
        input integer k;
        begin
            case (k)
                0: slot_name = 16'h4944;
                1: slot_name = 16'h4348;
                2: slot_name = 16'h4445;
                default: slot_name = 16'h4E49;
            endcase
        end
    endfunction

    always @* begin
        known    = 1'b0;
        rd_value = 8'h00;
        hit      = {NUM{1'b0}};
        for (j = 0; j < NUM; j = j + 1) begin
            if (name == slot_name(j)) begin
                hit[j]   = 1'b1;
                known    = 1'b1;
                rd_value = active[j];
            end
        end
        value_ok = (wr_value != 8'hFF);
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dirty <= {NUM{1'b0}};
            for (i = 0; i < NUM; i = i + 1) begin
                active[i]  <= 8'h00;
                pending[i] <= 8'h00;
            end
        end else begin
            for (i = 0; i < NUM; i = i + 1) begin
                if (apply && dirty[i]) begin
                    active[i] <= pending[i];
                end
                if (wr && hit[i] && value_ok) begin
                    pending[i] <= wr_value;
                    // A write that comes with its own apply takes effect at once
                    if (apply) begin
                        active[i] <= wr_value;
                    end
                end
            end
            dirty <= apply ? {NUM{1'b0}} : (dirty | ((wr && value_ok) ? hit : {NUM{1'b0}}));
        end
    end
endmodule

/* File: core/uas_cmd_parser.v */
// Application-service packet parser: decodes configuration and serial-data
// packets, answers with response or acknowledgement packets.
// Assumes packets arrive as byte streams with a last marker; the response
// receiver is always ready; the serial side drains the FIFO at its own pace.
//
// Behaviour
// - Configuration request has identifier 0x02; its options byte is ignored.
// - Frame identifier at offset 2 is never interpreted, only echoed.
// - Option 0 queues a write; option 2 applies all pending changes.
// - Command name is two ASCII characters at offsets 4 and 5.
// - Bytes after the name mean write; none mean read.
// - Every configuration request longer than its two header bytes gets a response with identifier 0x82.
// - Response options byte is 0x00.
// - Response frame identifier equals the request's.
// - Response echoes the name, then status 0 ok, 1 error, 2 unknown, 3 bad.
// - Successful reads of a setting append the value; all other responses omit it.
// - Serial-data packet has identifier 0; options bit 1 requests acknowledgement.
// - Serial payload is at most 1400 bytes and all goes to the serial port.
// - Acknowledgement has identifier 0x80, options zero, no further bytes.
// - Packets use UDP port 0xBEE; acknowledged only on request, no retries.
`timescale 1ns/1ps
`include "uas_defines.vh"
module uas_cmd_parser (
    input  wire       CLOCK,
    input  wire       SYS_RST,
    input  wire [7:0] RX_DATA,
    input  wire       RX_VALID,
    input  wire       RX_LAST,
    output reg        RX_READY,
    output reg  [7:0] TX_DATA,
    output reg        TX_VALID,
    output reg        TX_LAST,
    output reg  [7:0] SER_DATA,
    output reg        SER_VALID,
    input  wire       SER_READY,
    output reg        SER_OVERFLOW
);
    localparam S_HDR   = 3'd0;
    localparam S_CFG   = 3'd1;
    localparam S_SER   = 3'd2;
    localparam S_SKIP  = 3'd3;
    localparam S_RSP   = 3'd4;
    localparam S_ACK   = 3'd5;

    // Name of the apply-pending-changes command, two ASCII bytes
    localparam [15:0] NAME_APPLY = 16'h4143;
    // One past the offset of the last payload byte that may reach the serial port
    localparam [10:0] SER_END    = `UAS_SERIAL_START + `UAS_SERIAL_MAX;

    reg  [2:0]  state;
    reg  [10:0] idx;
    reg  [7:0]  cmd_id;
    reg  [7:0]  opts;
    reg  [7:0]  frame_id;
    reg  [7:0]  cfg_opt;
    reg  [15:0] name;
    reg         has_param;
    reg  [7:0]  param;
    reg         param_long;
    reg  [7:0]  status;
    reg  [7:0]  value;
    reg  [2:0]  rsp_len;
    reg  [2:0]  rsp_idx;
    reg  [7:0]  next_tx;

    wire        take;
    wire        fifo_in_ready;
    wire [7:0]  fifo_out_data;
    wire        fifo_out_valid;
    wire        ser_pop;
    wire        set_known;
    wire [7:0]  set_rd;
    wire        set_ok;
    reg         set_wr;
    reg         set_apply;
    reg         fifo_push;

    assign take = RX_VALID && RX_READY;

    // Serial output register takes a new byte whenever its slot empties
    assign ser_pop = fifo_out_valid && (!SER_VALID || SER_READY);

    uas_fifo #(
        .WIDTH (`UAS_FIFO_WIDTH),
        .DEPTH (`UAS_FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .in_data   (RX_DATA),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (ser_pop)
    );

    uas_settings #(
        .NUM (4)
    ) u_set (
        .clk      (CLOCK),
        .rst      (SYS_RST),
        .name     (name),
        .wr       (set_wr),
        .wr_value (param),
        .apply    (set_apply),
        .known    (set_known),
        .rd_value (set_rd),
        .value_ok (set_ok)
    );

    always @* begin
        fifo_push = take && (state == S_SER) && (idx < SER_END);
    end

    // Settings act in the first cycle of S_RSP, one cycle after the last request byte
    always @* begin
        set_wr    = 1'b0;
        set_apply = 1'b0;
        // A request answered with an error status changes nothing
        if (state == S_RSP && rsp_idx == 3'd0 && status == `UAS_ST_OK) begin
            set_wr    = has_param && (name != NAME_APPLY);
            set_apply = (name == NAME_APPLY) || (cfg_opt == `UAS_CFG_APPLY);
        end
    end

    // Response byte stream, contiguous layout
    always @* begin
        case (rsp_idx)
            3'd0: next_tx = `UAS_ID_CONFIG_RSP;
            3'd1: next_tx = `UAS_OPT_NONE;
            3'd2: next_tx = frame_id;
            3'd3: next_tx = `UAS_OPT_NONE;
            3'd4: next_tx = name[15:8];
            3'd5: next_tx = name[7:0];
            3'd6: next_tx = status;
            default: next_tx = value;
        endcase
    end

    always @* begin
        status = `UAS_ST_OK;
        if (name == NAME_APPLY) begin
            status = has_param ? `UAS_ST_BAD_PARAM : `UAS_ST_OK;
        end else if (!set_known) begin
            status = `UAS_ST_BAD_CMD;
        end else if (has_param && (param_long || !set_ok)) begin
            status = `UAS_ST_BAD_PARAM;
        end else if (cfg_opt != `UAS_CFG_QUEUE && cfg_opt != `UAS_CFG_APPLY) begin
            status = `UAS_ST_ERROR;
        end
    end

    always @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state        <= S_HDR;
            idx          <= 11'h000;
            cmd_id       <= 8'h00;
            opts         <= 8'h00;
            frame_id     <= 8'h00;
            cfg_opt      <= 8'h00;
            name         <= 16'h0000;
            has_param    <= 1'b0;
            param        <= 8'h00;
            param_long   <= 1'b0;
            value        <= 8'h00;
            rsp_len      <= 3'd0;
            rsp_idx      <= 3'd0;
            RX_READY     <= 1'b0;
            TX_DATA      <= 8'h00;
            TX_VALID     <= 1'b0;
            TX_LAST      <= 1'b0;
            SER_DATA     <= 8'h00;
            SER_VALID    <= 1'b0;
            SER_OVERFLOW <= 1'b0;
        end else begin
            if (ser_pop) begin
                SER_DATA  <= fifo_out_data;
                SER_VALID <= 1'b1;
            end else if (SER_READY) begin
                SER_VALID <= 1'b0;
            end
            TX_VALID <= 1'b0;
            TX_LAST  <= 1'b0;
            SER_OVERFLOW <= 1'b0;
            case (state)
                S_HDR: begin
                    // Header bytes are taken regardless of the FIFO; its back-pressure stalls only the payload
                    RX_READY <= 1'b1;
                    if (take) begin
                        idx <= idx + 11'h001;
                        if (idx == `UAS_OFF_ID) begin
                            cmd_id <= RX_DATA;
                        end
                        if (idx == `UAS_OFF_OPT) begin
                            opts <= RX_DATA;
                            if (cmd_id == `UAS_ID_SERIAL) begin
                                // Let the FIFO's flag reach ready before the payload
                                RX_READY <= 1'b0;
                                state <= S_SER;
                            end else if (cmd_id == `UAS_ID_CONFIG) begin
                                state <= S_CFG;
                            end else begin
                                state <= S_SKIP;
                            end
                        end
                        if (RX_LAST) begin
                            idx   <= 11'h000;
                            state <= S_HDR;
                            if (idx == `UAS_OFF_OPT && cmd_id == `UAS_ID_SERIAL &&
                                RX_DATA[`UAS_OPT_ACK_BIT]) begin
                                RX_READY <= 1'b0;
                                state    <= S_ACK;
                            end
                        end
                    end
                end
                S_SER: begin
                    // Ready is registered: drop it after each byte so a push that
                    // fills the FIFO is seen before the next byte is taken
                    RX_READY <= fifo_in_ready && !take;
                    if (take) begin
                        // Saturate so an overlong packet never wraps back into range
                        if (idx != 11'h7ff) begin
                            idx <= idx + 11'h001;
                        end
                        if (idx >= SER_END) begin
                            SER_OVERFLOW <= 1'b1;
                        end
                        if (RX_LAST) begin
                            idx      <= 11'h000;
                            RX_READY <= 1'b0;
                            state    <= opts[`UAS_OPT_ACK_BIT] ? S_ACK : S_HDR;
                        end
                    end
                end
                S_CFG: begin
                    RX_READY <= 1'b1;
                    if (take) begin
                        idx <= idx + 11'h001;
                        case (idx)
                            `UAS_OFF_FRAME:   frame_id <= RX_DATA;
                            `UAS_OFF_CFGOPT:  cfg_opt <= RX_DATA;
                            `UAS_OFF_NAME_HI: name[15:8] <= RX_DATA;
                            `UAS_OFF_NAME_LO: name[7:0] <= RX_DATA;
                            default: begin
                                if (idx == 11'h006) begin
                                    param     <= RX_DATA;
                                    has_param <= 1'b1;
                                end else if (idx > 11'h006) begin
                                    param_long <= 1'b1;
                                end
                            end
                        endcase
                        if (RX_LAST) begin
                            idx      <= 11'h000;
                            RX_READY <= 1'b0;
                            rsp_idx  <= 3'd0;
                            state    <= S_RSP;
                        end
                    end
                end
                S_RSP: begin
                    RX_READY <= 1'b0;
                    if (rsp_idx == 3'd0) begin
                        value   <= set_rd;
                        // Value byte only on a successful read
                        rsp_len <= (!has_param && status == `UAS_ST_OK &&
                                    name != NAME_APPLY) ? 3'd7 : 3'd6;
                    end
                    TX_DATA  <= next_tx;
                    TX_VALID <= 1'b1;
                    TX_LAST  <= (rsp_idx != 3'd0) && (rsp_idx == rsp_len);
                    rsp_idx  <= rsp_idx + 3'd1;
                    if (rsp_idx != 3'd0 && rsp_idx == rsp_len) begin
                        // Acknowledgements count from zero as well
                        rsp_idx    <= 3'd0;
                        has_param  <= 1'b0;
                        param_long <= 1'b0;
                        state      <= S_HDR;
                    end
                end
                S_ACK: begin
                    RX_READY <= 1'b0;
                    TX_VALID <= 1'b1;
                    if (rsp_idx == 3'd0) begin
                        TX_DATA <= `UAS_ID_ACK;
                        rsp_idx <= 3'd1;
                    end else begin
                        TX_DATA <= `UAS_OPT_NONE;
                        TX_LAST <= 1'b1;
                        rsp_idx <= 3'd0;
                        state   <= S_HDR;
                    end
                end
                S_SKIP: begin
                    RX_READY <= 1'b1;
                    if (take && RX_LAST) begin
                        idx   <= 11'h000;
                        state <= S_HDR;
                    end else if (take) begin
                        idx <= idx + 11'h001;
                    end
                end
                default: begin
                    state    <= S_HDR;
                    RX_READY <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: sim/uas_parser_monitor.sv */
// Checker for the packet parser: reply framing, timing and serial hold.
// Bound to uas_cmd_parser; sees only its ports.
`timescale 1ns/1ps
module uas_parser_monitor (
    input wire logic       CLOCK,
    input wire logic       SYS_RST,
    input wire logic [7:0] RX_DATA,
    input wire logic       RX_VALID,
    input wire logic       RX_LAST,
    input wire logic       RX_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_VALID,
    input wire logic       TX_LAST,
    input wire logic [7:0] SER_DATA,
    input wire logic       SER_VALID,
    input wire logic       SER_READY,
    input wire logic       SER_OVERFLOW
);
    logic [10:0] rx_idx;
    logic [7:0]  rx_id;
    logic [7:0]  rx_opt;
    logic [7:0]  rx_frame;
    logic [2:0]  tx_idx;
    wire logic   take = RX_VALID && RX_READY;
    // Options byte may itself be the last byte of a header-only packet
    wire logic   ack_req = (rx_idx == 11'h001) ? RX_DATA[1] : rx_opt[1];
    always @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_idx   <= 11'h000;
            rx_id    <= 8'h00;
            rx_opt   <= 8'h00;
            rx_frame <= 8'h00;
            tx_idx   <= 3'h0;
        end else begin
            if (take) begin
                rx_idx <= RX_LAST ? 11'h000 : rx_idx + 11'h001;
                if (rx_idx == 11'h000) rx_id <= RX_DATA;
                if (rx_idx == 11'h001) rx_opt <= RX_DATA;
                if (rx_idx == 11'h002) rx_frame <= RX_DATA;
            end
            if (TX_VALID) tx_idx <= TX_LAST ? 3'h0 : tx_idx + 3'h1;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    AST_CFG_RSP: assert property (take && RX_LAST && rx_id == 8'h02 && rx_idx >= 11'h005
        |-> ##2 TX_VALID && TX_DATA == 8'h82) else $error("config reply not started");
    AST_ACK_RSP: assert property (take && RX_LAST && rx_id == 8'h00 && rx_idx != 11'h000
        && ack_req |-> ##[1:4] (TX_VALID && TX_DATA == 8'h80)) else $error("ack missing");
    AST_OPT_ZERO: assert property (TX_VALID && tx_idx == 3'h1 |-> TX_DATA == 8'h00)
        else $error("reply options not zero");
    AST_FRAME_ECHO: assert property (TX_VALID && tx_idx == 3'h2 |-> TX_DATA == rx_frame)
        else $error("frame id not echoed");
    AST_ACK_LEN: assert property ($rose(TX_VALID) && TX_DATA == 8'h80
        |=> TX_VALID && TX_LAST) else $error("ack length wrong");
    AST_RSP_LEN: assert property ($rose(TX_VALID) && TX_DATA == 8'h82
        |-> TX_VALID [*7] ##[0:1] (TX_VALID && TX_LAST)) else $error("reply length wrong");
    AST_NO_RX_IN_TX: assert property (TX_VALID |-> !RX_READY)
        else $error("input open while replying");
    AST_SER_HOLD: assert property (SER_VALID && !SER_READY
        |=> SER_VALID && $stable(SER_DATA)) else $error("serial byte not held");
endmodule
bind uas_cmd_parser uas_parser_monitor i_mon (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_LAST(RX_LAST), .RX_READY(RX_READY),
    .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .SER_DATA(SER_DATA),
    .SER_VALID(SER_VALID), .SER_READY(SER_READY), .SER_OVERFLOW(SER_OVERFLOW));

/* File: sim/uas_client_model.sv */
// Network client model: feeds request packets, collects reply bytes.
// Assumes it is called on a falling edge; replies need no back-pressure.
`timescale 1ns/1ps
module uas_client_model (
    input  wire logic       CLOCK,
    input  wire logic       RX_READY,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    input  wire logic       TX_LAST,
    output logic      [7:0] RX_DATA,
    output logic            RX_VALID,
    output logic            RX_LAST
);
    logic [7:0] got [$];
    int         pkts = 0;
    logic       tmo = 1'b0;
    initial begin
        RX_DATA = 8'h00;
        RX_VALID = 1'b0;
        RX_LAST = 1'b0;
    end
    always @(posedge CLOCK) begin
        if (TX_VALID) begin
            got.push_back(TX_DATA);
            if (TX_LAST) pkts++;
        end
    end
    // Byte and marker held from one falling edge until an accepting rising edge
    task automatic send(input logic [7:0] b [$]);
        int n;
        foreach (b[i]) begin
            RX_DATA = b[i];
            RX_VALID = 1'b1;
            RX_LAST = (i == b.size() - 1);
            n = 0;
            while (!RX_READY && n < 5000) begin
                @(negedge CLOCK);
                n++;
            end
            tmo = tmo | (n >= 5000);
            @(negedge CLOCK);
        end
        RX_VALID = 1'b0;
        RX_LAST = 1'b0;
        // Released data must not look like the last byte
        RX_DATA = ~RX_DATA;
    endtask
endmodule

/* File: sim/udp_app_service_cmd_parser_tb.sv */
// Self-checking bench for the packet parser with a reference model.
// Assumes uas_cmd_parser, uas_client_model and the bound checker.
`timescale 1ns/1ps
module udp_app_service_cmd_parser_tb;
    logic        CLOCK;
    logic        SYS_RST;
    logic        SER_READY = 1'b0;
    logic [7:0]  RX_DATA, TX_DATA, SER_DATA;
    logic        RX_VALID, RX_LAST, RX_READY, TX_VALID, TX_LAST, SER_VALID, SER_OVERFLOW;
    int          num_errors = 0;
    int          checks = 0;
    int          ovf = 0;
    int          k;
    logic [7:0]  act [4];
    logic [7:0]  pend [4];
    logic        pnd [4];
    logic [7:0]  exp_ser [$];
    logic [7:0]  exp_tx [$];
    logic [7:0]  pkt [$];
    logic [15:0] names [6] = '{16'h4944, 16'h4348, 16'h4445, 16'h4e49, 16'h4143, 16'h5a5a};

    uas_cmd_parser i_uas_cmd_parser (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .RX_DATA(RX_DATA),
        .RX_VALID(RX_VALID), .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_DATA(TX_DATA),
        .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .SER_DATA(SER_DATA), .SER_VALID(SER_VALID),
        .SER_READY(SER_READY), .SER_OVERFLOW(SER_OVERFLOW));
    uas_client_model i_uas_client_model (.CLOCK(CLOCK), .RX_READY(RX_READY),
        .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .RX_DATA(RX_DATA),
        .RX_VALID(RX_VALID), .RX_LAST(RX_LAST));

    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    task automatic report_and_stop;
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    // Random stalls on the serial side so the FIFO fills and refuses
    always @(negedge CLOCK) SER_READY <= ($urandom % 3) != 0;
    always @(posedge CLOCK) begin
        if (!SYS_RST && SER_VALID && SER_READY) chk("serial byte", exp_ser.pop_front(), SER_DATA);
        if (!SYS_RST && SER_OVERFLOW) ovf++;
    end

    task automatic xfer(input int rsp);
        int n;
        int want;
        want = i_uas_client_model.pkts + rsp;
        i_uas_client_model.send(pkt);
        n = 0;
        // Next packet only after the reply has arrived
        while (i_uas_client_model.pkts < want && n < 300) begin
            @(negedge CLOCK);
            n++;
        end
        if (!rsp) repeat (12) @(negedge CLOCK);
        if (n >= 300 || i_uas_client_model.tmo) begin
            num_errors++;
            report_and_stop();
        end
        chk("tx length", 8'(exp_tx.size()), 8'(i_uas_client_model.got.size()));
        foreach (exp_tx[i]) chk("tx byte", exp_tx[i], i_uas_client_model.got[i]);
        i_uas_client_model.got.delete();
    endtask

    // nm 0..3 settings, 4 apply-all command, 5 unknown name
    task automatic cfg(input logic [7:0] opt, input int nm, input int np, input logic [7:0] v);
        logic [7:0] st;
        logic [7:0] fr;
        fr = $urandom;
        pkt = '{8'h02, 8'($urandom), fr, opt, names[nm][15:8], names[nm][7:0]};
        repeat (np) pkt.push_back(v);
        if (nm == 5) st = 8'h02;
        else if (np > 1 || (nm == 4 && np > 0)) st = 8'h03;
        else if (opt != 8'h00 && opt != 8'h02) st = 8'h01;
        else if (np > 0 && v == 8'hff) st = 8'h03;
        else st = 8'h00;
        if (st == 8'h00 && nm < 4 && np > 0) begin
            pend[nm] = v;
            pnd[nm] = 1'b1;
        end
        if (st == 8'h00 && (nm == 4 || opt == 8'h02)) begin
            for (int j = 0; j < 4; j++) begin
                if (pnd[j]) act[j] = pend[j];
                pnd[j] = 1'b0;
            end
        end
        exp_tx = '{8'h82, 8'h00, fr, 8'h00, names[nm][15:8], names[nm][7:0], st};
        if (st == 8'h00 && np == 0 && nm < 4) exp_tx.push_back(act[nm]);
        xfer(1);
    endtask

    task automatic ser(input int len, input logic ack);
        int n;
        logic [7:0] b;
        pkt = '{8'h00, {6'h00, ack, 1'b0}};
        for (int j = 0; j < len; j++) begin
            b = $urandom;
            pkt.push_back(b);
            if (j < 1400) exp_ser.push_back(b);
        end
        exp_tx = {};
        if (ack) exp_tx = '{8'h80, 8'h00};
        xfer(int'(ack));
        n = 0;
        while (exp_ser.size() != 0 && n < 5000) begin
            @(negedge CLOCK);
            n++;
        end
        chk("serial left", 8'h00, 8'(exp_ser.size()));
        if (n >= 5000) begin
            num_errors++;
            report_and_stop();
        end
    endtask

    initial begin
        void'($urandom(54407));
        SYS_RST = 1'b1;
        for (k = 0; k < 4; k++) begin
            act[k] = 8'h00;
            pnd[k] = 1'b0;
        end
        repeat (6) @(negedge CLOCK);
        SYS_RST = 1'b0;
        repeat (2) @(negedge CLOCK);
        for (k = 0; k < 4; k++) cfg(8'h00, k, 0, 8'h00);
        for (k = 0; k < 4; k++) cfg(8'h00, k, 1, 8'($urandom_range(0, 254)));
        for (k = 0; k < 4; k++) cfg(8'h00, k, 0, 8'h00);
        cfg(8'h00, 4, 0, 8'h00);
        for (k = 0; k < 4; k++) cfg(8'h00, k, 0, 8'h00);
        cfg(8'h02, 2, 1, 8'h5a);
        cfg(8'h00, 2, 0, 8'h00);
        cfg(8'h00, 5, 0, 8'h00);
        cfg(8'h00, 1, 1, 8'hff);
        cfg(8'h01, 1, 1, 8'h11);
        cfg(8'h00, 1, 2, 8'h22);
        cfg(8'h00, 4, 1, 8'h00);
        cfg(8'h00, 1, 0, 8'h00);
        pkt = '{8'h05, 8'h00, 8'h33};
        exp_tx = {};
        xfer(0);
        for (k = 0; k < 6; k++) ser($urandom_range(1, 40), k[0]);
        // Resend as if the acknowledgement had been lost: the payload goes out twice
        for (k = 2; k < pkt.size(); k++) exp_ser.push_back(pkt[k]);
        exp_tx = '{8'h80, 8'h00};
        xfer(1);
        ser(0, 1'b1);
        ser(1402, 1'b1);
        chk("overflow count", 8'h02, 8'(ovf));
        report_and_stop();
    end
endmodule
